// ### common/adc_ctrl_pkg.sv
// Constants, register map and carrier types for the paired-input converter control
package adc_ctrl_pkg;
  localparam int NUM_PAIRS = 6;
  localparam int NUM_PINS = 12;
  localparam int RES_BITS = 10;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 5;
  localparam int DIV_W = 3;
  // Converter clock timing, in converter clocks
  localparam int SAMPLE_CLKS = 2;
  localparam int HOLD_CLKS = 2;
  localparam int CONV_CLKS = 10;
  localparam int PAIR_CLKS = 2 * (HOLD_CLKS + CONV_CLKS);
  // Register indices
  localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_PIN_CFG = 5'h01;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h02;
  localparam logic [ADDR_W-1:0] OFS_JUMP = 5'h03;
  localparam logic [ADDR_W-1:0] OFS_PORT = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_DIR = 5'h05;
  localparam logic [ADDR_W-1:0] OFS_TRIG = 5'h06;
  localparam logic [ADDR_W-1:0] OFS_RESULT = 5'h08;
  // Field positions
  localparam int CTRL_ON_BIT = 15;
  localparam int CTRL_DIV_LSB = 0;
  localparam int STAT_PEND_LSB = 8;
  localparam int JUMP_SHIFT = 2;
  // Reset values
  localparam logic [DATA_W-1:0] CTRL_RST = 16'h0000;
  localparam logic [NUM_PINS-1:0] PIN_CFG_RST = 12'h000;
  localparam logic [NUM_PINS-1:0] DIR_RST = 12'hFFF;
  localparam logic [NUM_PAIRS-1:0] TRIG_RST = 6'h00;
  localparam logic [DATA_W-1:0] JUMP_RST = 16'h0000;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [NUM_PINS-1:0] tie_ground;
    logic [NUM_PINS-1:0] dig_buf_off;
  } pin_ctl_t;
endpackage : adc_ctrl_pkg

// ### rtl/adc_clock_divider.sv
// Converter clock tick generator dividing the system clock
`timescale 1ns/1ps
`default_nettype none
module adc_clock_divider
  import adc_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Control
  input wire logic run_i,
  input wire logic [DIV_W-1:0] div_i,
  // Tick
  output logic tick_o
);
  logic [DIV_W-1:0] count_reg;

  // Period is div_i + 1 system clocks; held in reset while the module is off
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_reg <= '0;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      count_reg <= '0;
      tick_o <= 1'b0;
    end else if (count_reg >= div_i) begin
      count_reg <= '0;
      tick_o <= 1'b1;
    end else begin
      count_reg <= count_reg + 3'h1;
      tick_o <= 1'b0;
    end
  end

  AST_DIV_STOPS_WHEN_OFF: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ9]
    !run_i |=> !tick_o) else $error("converter tick while module off");
endmodule : adc_clock_divider
`default_nettype wire

// ### rtl/sample_hold_unit.sv
// One sample-and-hold timing unit for an input pair
`timescale 1ns/1ps
`default_nettype none
module sample_hold_unit
  import adc_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Control
  input wire logic module_on_i,
  input wire logic adc_tick_i,
  input wire logic trigger_i,
  input wire logic grant_i,
  // Status
  output logic sampling_o,
  output logic pending_o
);
  typedef enum logic [1:0] {SH_IDLE, SH_WAIT, SH_SAMPLE, SH_PENDING} sh_state_t;
  sh_state_t state_reg;
  logic [1:0] cnt_reg;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= SH_IDLE;
      cnt_reg <= '0;
    end else if (!module_on_i) begin
      state_reg <= SH_IDLE; // [RQ9] [RQ11]
      cnt_reg <= '0;
    end else begin
      case (state_reg)
        SH_IDLE: begin
          if (trigger_i) begin
            state_reg <= SH_WAIT; // [RQ3] [RQ6]
            cnt_reg <= '0;
          end
        end
        // Window opens on a converter tick so it spans whole converter periods, at up to one period of latency
        SH_WAIT: begin
          if (adc_tick_i) begin
            state_reg <= SH_SAMPLE; // [RQ2] [RQ3] [RQ4]
            cnt_reg <= '0;
          end
        end
        SH_SAMPLE: begin
          // Retriggers here and while pending are dropped, not queued
          if (adc_tick_i) begin
            if (cnt_reg == 2'(SAMPLE_CLKS - 1)) begin
              state_reg <= SH_PENDING; // [RQ2] [RQ4] [RQ6]
            end else begin
              cnt_reg <= cnt_reg + 2'h1;
            end
          end
        end
        SH_PENDING: begin
          if (grant_i) begin
            state_reg <= SH_IDLE; // [RQ4]
          end
        end
        default: state_reg <= SH_IDLE;
      endcase
    end
  end

  assign sampling_o = (state_reg == SH_SAMPLE);
  assign pending_o = (state_reg == SH_PENDING);

  AST_SH_TWO_CLOCKS: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ2]
    $rose(pending_o) |-> $past(adc_tick_i) && $past(cnt_reg) == 2'h1)
    else $error("sampling did not last two converter clocks");
  AST_SH_RETRIGGER_IGNORED: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ4]
    (pending_o && trigger_i && !grant_i && module_on_i) |=> pending_o && !sampling_o)
    else $error("retrigger disturbed a pending request");
endmodule : sample_hold_unit
`default_nettype wire

// ### rtl/adc_pair_control.sv
// Paired-input converter control: registers, request arbitration and serial conversion
// Functional notes
// RQ1 - Software keeps divisor fixed while module on
// RQ2 - Sampling lasts exactly two converter clocks
// RQ3 - Trigger starts sampling; conversion waits converter
// RQ4 - Retrigger while request unserviced is dropped
// RQ5 - Ten clocks, bit 9 first, store at end
// RQ6 - Each sample unit flags pending after sampling
// RQ7 - Both inputs converted; pair takes 24 clocks
// RQ8 - Module on: fully functional
// RQ9 - Module off: idle state, pending requests cleared
// RQ10 - Software waits for bias settling after enable
// RQ11 - Reset clears registers, aborts, keeps results
// RQ12 - Result buffers have no reset value
// RQ13 - Config bit clear: analog, digital buffer off
// RQ14 - Config bit set: input tied to ground
// RQ15 - Port read gives zero for analog pins
// RQ16 - Converter ignores direction and selection bits
// RQ17 - Jump register read gives table address
// RQ18 - Software clears controller flag before ready flag
// RQ19 - Jump LSB zero; pair number shifted two
// RQ20 - Ready flags prioritised, pair zero highest
// RQ21 - Ready flag set at completion until cleared
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module adc_pair_control
  import adc_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Register port
  input wire reg_req_t bus_req_i,
  output logic [DATA_W-1:0] rdata_o,
  // Triggers and analog front end
  input wire logic [NUM_PAIRS-1:0] trig_i,
  input wire logic comp_i,
  input wire logic [NUM_PINS-1:0] pin_level_i,
  output logic [NUM_PINS-1:0] hold_o,
  output logic [3:0] conv_sel_o,
  output logic [RES_BITS-1:0] dac_code_o,
  output pin_ctl_t pin_ctl_o,
  // Status
  output logic busy_o
);
  typedef enum logic [1:0] {CV_IDLE, CV_HOLD, CV_BITS} cv_state_t;

  cv_state_t state_reg;
  logic module_on_reg;
  logic [DIV_W-1:0] div_reg;
  logic [NUM_PINS-1:0] pin_cfg_reg;
  logic [NUM_PINS-1:0] dir_reg;
  logic [NUM_PAIRS-1:0] trig_en_reg;
  logic [DATA_W-1:1] base_reg;
  logic [NUM_PAIRS-1:0] ready_reg;
  logic [NUM_PAIRS-1:0] ready_next;
  logic [RES_BITS-1:0] result_buf [NUM_PINS];
  logic [2:0] pair_reg;
  logic second_reg;
  logic [3:0] cnt_reg;
  logic [RES_BITS-1:0] code_reg;
  logic adc_tick;
  logic [NUM_PAIRS-1:0] sampling_vec;
  logic [NUM_PAIRS-1:0] pending_vec;
  logic [NUM_PAIRS-1:0] grant_vec;
  logic [2:0] grant_idx;
  logic [2:0] ready_idx;
  logic pair_done;
  logic [3:0] res_idx;
  logic wr_hit;
  logic rd_hit;
  logic [DATA_W-1:0] rd_val;
  logic [4:0] pair_ticks;

  assign wr_hit = bus_req_i.wr;
  assign rd_hit = bus_req_i.rd;

  adc_clock_divider u_div (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .run_i(module_on_reg),
    .div_i(div_reg),
    .tick_o(adc_tick)
  );

  // Trigger enables gate the external sources per pair
  for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_sh
    sample_hold_unit u_sh (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .module_on_i(module_on_reg),
      .adc_tick_i(adc_tick),
      .trigger_i(trig_i[p] & trig_en_reg[p]), // [RQ3] [RQ8]
      .grant_i(grant_vec[p]),
      .sampling_o(sampling_vec[p]),
      .pending_o(pending_vec[p])
    );
  end

  // Lowest-numbered pending pair is served first, no round robin
  always_comb begin
    grant_idx = 3'h0;
    for (int i = NUM_PAIRS - 1; i >= 0; i--) begin
      if (pending_vec[i]) begin
        grant_idx = 3'(i);
      end
    end
    grant_vec = '0;
    if (module_on_reg && state_reg == CV_IDLE && pending_vec != '0) begin
      grant_vec[grant_idx] = 1'b1; // [RQ3] [RQ20]
    end
  end

  always_comb begin
    ready_idx = 3'h0;
    for (int i = NUM_PAIRS - 1; i >= 0; i--) begin
      if (ready_reg[i]) begin
        ready_idx = 3'(i); // [RQ20]
      end
    end
  end

  assign pair_done = (state_reg == CV_BITS) && adc_tick && (cnt_reg == 4'h0) && second_reg;
  assign res_idx = {pair_reg, second_reg};

  // Control register; the divisor must not be changed while on
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      module_on_reg <= CTRL_RST[CTRL_ON_BIT]; // [RQ11]
      div_reg <= CTRL_RST[CTRL_DIV_LSB +: DIV_W];
    end else if (wr_hit && bus_req_i.addr == OFS_CTRL) begin
      module_on_reg <= bus_req_i.wdata[CTRL_ON_BIT]; // [RQ8] [RQ10]
      div_reg <= bus_req_i.wdata[CTRL_DIV_LSB +: DIV_W]; // [RQ1]
    end
  end

  // Configuration registers
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_cfg_reg <= PIN_CFG_RST;
      dir_reg <= DIR_RST;
      trig_en_reg <= TRIG_RST;
      base_reg <= JUMP_RST[DATA_W-1:1];
    end else if (wr_hit) begin
      case (bus_req_i.addr)
        OFS_PIN_CFG: pin_cfg_reg <= bus_req_i.wdata[NUM_PINS-1:0];
        // Direction is stored for readback only; the converter never looks at it
        OFS_DIR: dir_reg <= bus_req_i.wdata[NUM_PINS-1:0]; // [RQ16]
        OFS_TRIG: trig_en_reg <= bus_req_i.wdata[NUM_PAIRS-1:0];
        OFS_JUMP: base_reg <= bus_req_i.wdata[DATA_W-1:1]; // [RQ19]
        default: begin
        end
      endcase
    end
  end

  // Ready flags: a zero written clears, completion in the same cycle wins
  always_comb begin
    ready_next = ready_reg;
    if (wr_hit && bus_req_i.addr == OFS_STATUS) begin
      ready_next = ready_reg & bus_req_i.wdata[NUM_PAIRS-1:0];
    end
    if (pair_done) begin
      ready_next[pair_reg] = 1'b1; // [RQ21]
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ready_reg <= '0;
    end else begin
      ready_reg <= ready_next; // [RQ21]
    end
  end

  // Conversion sequencer: per input two hold clocks then ten bit clocks
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= CV_IDLE; // [RQ11]
      pair_reg <= '0;
      second_reg <= 1'b0;
      cnt_reg <= '0;
      code_reg <= '0;
    end else if (!module_on_reg) begin
      state_reg <= CV_IDLE; // [RQ9]
      second_reg <= 1'b0;
      cnt_reg <= '0;
      code_reg <= '0;
    end else begin
      case (state_reg)
        CV_IDLE: begin
          if (grant_vec != '0) begin
            state_reg <= CV_HOLD; // [RQ3]
            pair_reg <= grant_idx;
            second_reg <= 1'b0;
            cnt_reg <= '0;
          end
        end
        CV_HOLD: begin
          if (adc_tick) begin
            if (cnt_reg == 4'(HOLD_CLKS - 1)) begin
              state_reg <= CV_BITS;
              cnt_reg <= 4'(CONV_CLKS - 1); // [RQ5]
              code_reg <= 10'h200;
            end else begin
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
        end
        CV_BITS: begin
          if (adc_tick) begin
            code_reg[cnt_reg] <= comp_i; // [RQ5]
            if (cnt_reg != 4'h0) begin
              code_reg[cnt_reg - 4'h1] <= 1'b1;
              cnt_reg <= cnt_reg - 4'h1;
            end else if (!second_reg) begin
              state_reg <= CV_HOLD; // [RQ7]
              second_reg <= 1'b1;
              cnt_reg <= '0;
            end else begin
              state_reg <= CV_IDLE;
              second_reg <= 1'b0;
            end
          end
        end
        default: state_reg <= CV_IDLE;
      endcase
    end
  end

  // Result storage has no reset so a device reset leaves it intact
  always_ff @(posedge core_clk_i) begin
    if (state_reg == CV_BITS && adc_tick && cnt_reg == 4'h0 && module_on_reg) begin
      result_buf[res_idx] <= {code_reg[RES_BITS-1:1], comp_i}; // [RQ5] [RQ11] [RQ12]
    end
  end

  // Read mux; data appear in the cycle after the strobe
  always_comb begin
    rd_val = '0;
    case (bus_req_i.addr)
      OFS_CTRL: begin
        rd_val[CTRL_ON_BIT] = module_on_reg;
        rd_val[CTRL_DIV_LSB +: DIV_W] = div_reg;
      end
      OFS_PIN_CFG: rd_val[NUM_PINS-1:0] = pin_cfg_reg;
      OFS_STATUS: begin
        rd_val[NUM_PAIRS-1:0] = ready_reg;
        rd_val[STAT_PEND_LSB +: NUM_PAIRS] = pending_vec;
      end
      OFS_JUMP: rd_val = {base_reg, 1'b0} + {11'h000, ready_idx, 2'h0}; // [RQ17] [RQ19]
      OFS_PORT: rd_val[NUM_PINS-1:0] = pin_level_i & pin_cfg_reg; // [RQ15]
      OFS_DIR: rd_val[NUM_PINS-1:0] = dir_reg;
      OFS_TRIG: rd_val[NUM_PAIRS-1:0] = trig_en_reg;
      default: begin
        if (bus_req_i.addr >= OFS_RESULT && bus_req_i.addr < OFS_RESULT + 5'(NUM_PINS)) begin
          rd_val[RES_BITS-1:0] = result_buf[4'(bus_req_i.addr - OFS_RESULT)];
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= '0;
    end else if (rd_hit) begin
      rdata_o <= rd_val;
    end else begin
      rdata_o <= '0;
    end
  end

  // Registered analog front-end controls
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hold_o <= '0;
      conv_sel_o <= '0;
      dac_code_o <= '0;
      busy_o <= 1'b0;
      pin_ctl_o <= '0;
    end else begin
      for (int p = 0; p < NUM_PAIRS; p++) begin
        hold_o[2*p] <= sampling_vec[p];
        hold_o[2*p+1] <= sampling_vec[p];
      end
      conv_sel_o <= res_idx;
      dac_code_o <= code_reg;
      busy_o <= (state_reg != CV_IDLE);
      pin_ctl_o.tie_ground <= pin_cfg_reg; // [RQ14]
      pin_ctl_o.dig_buf_off <= ~pin_cfg_reg; // [RQ13]
    end
  end

  // Helper: converter clocks consumed by the current pair
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pair_ticks <= '0;
    end else if (grant_vec != '0) begin
      pair_ticks <= '0;
    end else if (state_reg != CV_IDLE && adc_tick) begin
      pair_ticks <= pair_ticks + 5'h01;
    end
  end

  AST_PAIR_24_CLOCKS: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ7]
    pair_done |-> pair_ticks == 5'(PAIR_CLKS - 1))
    else $error("pair conversion length wrong");
  AST_OFF_GOES_IDLE: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ9]
    !module_on_reg |=> state_reg == CV_IDLE ##1 !busy_o)
    else $error("module off did not idle the sequencer");
  AST_BITS_MSB_FIRST: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ5]
    (state_reg == CV_HOLD && adc_tick && cnt_reg == 4'h1 && module_on_reg)
      |=> state_reg == CV_BITS && cnt_reg == 4'h9)
    else $error("conversion did not start at bit 9");
  AST_READY_STICKY: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ21]
    !(wr_hit && bus_req_i.addr == OFS_STATUS) |=> (ready_reg & $past(ready_reg)) == $past(ready_reg))
    else $error("ready flag dropped without software clear");
  AST_DONE_SETS_READY: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ21]
    pair_done |=> ready_reg[$past(pair_reg)])
    else $error("completion did not set ready flag");
  AST_JUMP_LSB_ZERO: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ19]
    (rd_hit && bus_req_i.addr == OFS_JUMP) |=> !rdata_o[0])
    else $error("jump address LSB not zero");
  AST_PORT_ANALOG_ZERO: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ15]
    (rd_hit && bus_req_i.addr == OFS_PORT) |=> (rdata_o[NUM_PINS-1:0] & ~$past(pin_cfg_reg)) == '0)
    else $error("analog pin read nonzero");
  AST_GRANT_LOWEST: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ20]
    (grant_vec != '0) |-> grant_vec == (pending_vec & (~pending_vec + 6'h01)))
    else $error("grant not to lowest pending pair");
endmodule : adc_pair_control
`default_nettype wire

// ### bench/analog_front_model.sv
// Analog front end model: per-pin levels, ground tie and comparator
`timescale 1ns/1ps
`default_nettype none
module analog_front_model
  import adc_ctrl_pkg::*;
(
  // Analog levels, pin n at bits n*RES_BITS upward
  input wire logic [NUM_PINS*RES_BITS-1:0] level_i,
  // Converter side
  input wire logic [3:0] conv_sel_i,
  input wire logic [RES_BITS-1:0] dac_code_i,
  input wire pin_ctl_t pin_ctl_i,
  output logic comp_o
);
  logic [RES_BITS-1:0] held;

  // Select code {pair,input} is the pin index; codes past the last pin see ground
  always_comb begin
    held = '0;
    if (conv_sel_i < 4'(NUM_PINS)) begin
      held = level_i[conv_sel_i*RES_BITS +: RES_BITS];
      if (pin_ctl_i.tie_ground[conv_sel_i]) begin
        held = '0;
      end
    end
    comp_o = (held >= dac_code_i);
  end
endmodule : analog_front_model
`default_nettype wire

// ### bench/test_adc_pair_control.sv
// Self-checking bench for the paired-input converter control
`timescale 1ns/1ps
`default_nettype none
module test_adc_pair_control;
  import adc_ctrl_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  reg_req_t bus_req_i = '0;
  logic [NUM_PAIRS-1:0] trig_i = '0;
  logic [NUM_PINS-1:0] pin_level_i = '0;
  logic [NUM_PINS*RES_BITS-1:0] level = '0;
  logic comp_i;
  logic [DATA_W-1:0] rdata_o;
  logic [NUM_PINS-1:0] hold_o;
  logic [3:0] conv_sel_o;
  logic [RES_BITS-1:0] dac_code_o;
  pin_ctl_t pin_ctl_o;
  logic busy_o;
  logic [DATA_W-1:0] rd_val;
  int miscompares = 0;
  int total_checks = 0;

  always #10 core_clk_i = ~core_clk_i;

  adc_pair_control DUT (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .bus_req_i(bus_req_i),
    .rdata_o(rdata_o),
    .trig_i(trig_i),
    .comp_i(comp_i),
    .pin_level_i(pin_level_i),
    .hold_o(hold_o),
    .conv_sel_o(conv_sel_o),
    .dac_code_o(dac_code_o),
    .pin_ctl_o(pin_ctl_o),
    .busy_o(busy_o)
  );

  analog_front_model front (
    .level_i(level),
    .conv_sel_i(conv_sel_o),
    .dac_code_i(dac_code_o),
    .pin_ctl_i(pin_ctl_o),
    .comp_o(comp_i)
  );

  task automatic results;
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk_i);
    bus_req_i <= reg_req_t'{1'b1, 1'b0, a, d};
    @(posedge core_clk_i);
    bus_req_i <= '0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge core_clk_i);
    bus_req_i <= reg_req_t'{1'b0, 1'b1, a, 16'h0000};
    @(posedge core_clk_i);
    bus_req_i <= '0;
    #1 rd_val = rdata_o;
  endtask : rd

  task automatic pulse(input logic [NUM_PAIRS-1:0] p);
    @(posedge core_clk_i);
    trig_i <= p;
    @(posedge core_clk_i);
    trig_i <= '0;
  endtask : pulse

  task automatic set_level(input int pin, input logic [RES_BITS-1:0] v);
    level[pin*RES_BITS +: RES_BITS] = v;
  endtask : set_level

  // One clock of a bounded wait; running out of cycles is a mismatch
  task automatic step(inout int n, input int lim);
    @(posedge core_clk_i);
    #1 n++;
    if (n > lim) begin
      miscompares++;
      results();
    end
  endtask : step

  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy_o !== lvl) begin
      step(n, 500);
    end
  endtask : wait_busy

  task automatic t_reset_values;
    logic [ADDR_W-1:0] a [8] = '{OFS_CTRL, OFS_PIN_CFG, OFS_STATUS, OFS_JUMP, OFS_DIR, OFS_TRIG, 5'h07, 5'h1F};
    logic [DATA_W-1:0] e [8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0FFF, 16'h0000, 16'h0000, 16'h0000};
    for (int i = 0; i < 8; i++) begin
      rd(a[i]);
      check(rd_val, e[i]);
    end
  endtask : t_reset_values

  task automatic t_pin_config;
    @(posedge core_clk_i);
    pin_level_i <= 12'hA5C;
    wr(OFS_PIN_CFG, 16'h0F0F);
    rd(OFS_PORT);
    check(rd_val, 16'h0A0C);
    check(16'(pin_ctl_o.tie_ground), 16'h0F0F);
    check(16'(pin_ctl_o.dig_buf_off), 16'h00F0);
    wr(OFS_PIN_CFG, 16'h0000);
  endtask : t_pin_config

  // Pair 2 at divisor 1: every converter clock is two system clocks
  task automatic t_convert;
    int n;
    set_level(4, 10'h2B7);
    set_level(5, 10'h3FF);
    wr(OFS_DIR, 16'h0000);
    wr(OFS_JUMP, 16'h0361);
    wr(OFS_TRIG, 16'h0004);
    wr(OFS_CTRL, 16'h8001);
    pulse(6'h04);
    n = 0;
    while (hold_o[4] !== 1'b1) begin
      step(n, 50);
    end
    check(16'(hold_o[5:4]), 16'h0003);
    n = 0;
    while (hold_o[4] === 1'b1) begin
      step(n, 50);
    end
    check(16'(n), 16'(SAMPLE_CLKS * 2));
    wait_busy(1'b1);
    n = 0;
    while (busy_o === 1'b1) begin
      step(n, 200);
    end
    check(16'(n >= PAIR_CLKS * 2 - 1 && n <= PAIR_CLKS * 2 + 4), 16'h0001);
    rd(OFS_RESULT + 5'h04);
    check(rd_val, 16'h02B7);
    rd(OFS_RESULT + 5'h05);
    check(rd_val, 16'h03FF);
    rd(OFS_STATUS);
    check(rd_val, 16'h0004);
    rd(OFS_JUMP);
    check(rd_val, 16'h0368);
    wr(OFS_STATUS, 16'h0000);
    rd(OFS_STATUS);
    check(rd_val, 16'h0000);
  endtask : t_convert

  // Pairs 1 and 4 together, pair 4 retriggered while still waiting its turn
  task automatic t_priority_retrigger;
    int n;
    set_level(2, 10'h155);
    set_level(8, 10'h0AA);
    wr(OFS_TRIG, 16'h0012);
    pulse(6'h12);
    wait_busy(1'b1);
    n = 0;
    for (int i = 0; i < 240; i++) begin
      @(posedge core_clk_i);
      trig_i <= (i == 10 || i == 12) ? 6'h10 : 6'h00;
      #1;
      if (busy_o === 1'b1) begin
        n++;
      end
    end
    // The first busy cycle is spent by wait_busy and one idle cycle falls between the pairs
    check(16'(n >= 4 * PAIR_CLKS - 4 && n <= 4 * PAIR_CLKS + 8), 16'h0001);
    rd(OFS_STATUS);
    check(rd_val, 16'h0012);
    rd(OFS_JUMP);
    check(rd_val, 16'h0364);
    wr(OFS_STATUS, 16'h003D);
    rd(OFS_JUMP);
    check(rd_val, 16'h0370);
    rd(OFS_RESULT + 5'h02);
    check(rd_val, 16'h0155);
    rd(OFS_RESULT + 5'h08);
    check(rd_val, 16'h00AA);
    wr(OFS_STATUS, 16'h0000);
  endtask : t_priority_retrigger

  // Switching off mid-conversion, triggers while off, then a grounded pin
  task automatic t_off_ground;
    set_level(0, 10'h3C3);
    set_level(1, 10'h001);
    wr(OFS_TRIG, 16'h0001);
    pulse(6'h01);
    wait_busy(1'b1);
    repeat (6) @(posedge core_clk_i);
    // Only the on bit changes; the divisor keeps its value
    wr(OFS_CTRL, 16'h0001);
    repeat (3) @(posedge core_clk_i);
    #1 check(16'(busy_o), 16'h0000);
    pulse(6'h01);
    repeat (4) @(posedge core_clk_i);
    #1 check(16'(hold_o), 16'h0000);
    wr(OFS_CTRL, 16'h8001);
    // Bias settling time after switching on
    repeat (100) @(posedge core_clk_i);
    #1 check(16'(busy_o), 16'h0000);
    rd(OFS_STATUS);
    check(rd_val, 16'h0000);
    wr(OFS_PIN_CFG, 16'h0001);
    pulse(6'h01);
    wait_busy(1'b1);
    wait_busy(1'b0);
    rd(OFS_RESULT);
    check(rd_val, 16'h0000);
    rd(OFS_RESULT + 5'h01);
    check(rd_val, 16'h0001);
  endtask : t_off_ground

  // Reset during a conversion keeps the result buffers
  task automatic t_reset_mid;
    wr(OFS_PIN_CFG, 16'h0000);
    wr(OFS_STATUS, 16'h0000);
    pulse(6'h01);
    wait_busy(1'b1);
    repeat (4) @(posedge core_clk_i);
    rst_b_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    #1 check(16'(busy_o), 16'h0000);
    check(16'(hold_o), 16'h0000);
    @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    rd(OFS_CTRL);
    check(rd_val, 16'h0000);
    rd(OFS_TRIG);
    check(rd_val, 16'h0000);
    rd(OFS_RESULT + 5'h01);
    check(rd_val, 16'h0001);
    rd(OFS_RESULT + 5'h04);
    check(rd_val, 16'h02B7);
  endtask : t_reset_mid

  initial begin
    repeat (20) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    t_reset_values();
    t_pin_config();
    t_convert();
    t_priority_retrigger();
    t_off_ground();
    t_reset_mid();
    results();
  end
endmodule : test_adc_pair_control
`default_nettype wire
